/* File: hw/adcs_consts.svh */
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADCS_ADDR_W 12
`define ADCS_IDX_DATA 10'h000
`define ADCS_DATA_REGS 10'h020
`define ADCS_IDX_THR 10'h0f4
`define ADCS_THR_REGS 10'h008
`define ADCS_IDX_CTL_A 10'h0fc
`define ADCS_IDX_CTL_B 10'h0fd
`define ADCS_IDX_ICR 10'h0fe
`define ADCS_IDX_CRR 10'h0ff
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCS_CA_PAIR 7:4
`define ADCS_CA_FIRST 3:0
`define ADCS_CB_PRE 7:5
`define ADCS_CB_TIMER 4
`define ADCS_CB_EXT 3
`define ADCS_CB_POW 2
`define ADCS_CB_CONT 1
`define ADCS_CB_GO 0
`define ADCS_IC_EOC 7
`define ADCS_IC_AWD 6
`define ADCS_IC_EOC_EN 5
`define ADCS_IC_AWD_EN 4
`define ADCS_IC_LVL 2:0
// ----------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------
`define ADCS_LAST_CH 4'hf
`define ADCS_PRE_ZERO 4'h8
`define ADCS_SAMPLE_MUL 10'h008
`define ADCS_CONV_MUL 10'h01c
`define ADCS_ANALOG_CONV_CLOCK_MAX_HZ 32'h003d_0900
`define ADCS_RESP_OKAY 2'h0
`define ADCS_RESP_SLVERR 2'h2
`endif

/* File: hw/adcs_pkg.sv */
`include "adcs_consts.svh"
package adcs_pkg;
	typedef enum logic [0:0] {
		ADCS_IDLE = 1'b0,
		ADCS_CONV = 1'b1
	} adcs_state_e;

	typedef struct packed {
		logic awvalid;
		logic [`ADCS_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`ADCS_ADDR_W-1:0] araddr;
		logic rready;
	} adcs_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} adcs_axi_resp_s;

	typedef struct packed {
		logic power_up;
		logic conv_clock;
		logic sample;
		logic busy;
		logic [3:0] channel;
	} adcs_core_s;

	typedef struct packed {
		logic aw_v;
		logic [`ADCS_ADDR_W-1:0] aw_a;
		logic w_v;
		logic [7:0] w_d;
		logic w_s;
		logic b_v;
		logic [1:0] b_r;
		logic r_v;
		logic [7:0] r_d;
		logic [1:0] r_r;
		logic [7:0] ctl_a;
		logic [7:0] ctl_b;
		logic [7:0] interrupt_control_reg;
		logic [3:0] compare_result_flags;
		logic [3:0][9:0] thr;
		logic [15:0][9:0] data;
		logic ext_s1;
		logic ext_s2;
		logic trig_q;
		adcs_state_e st;
		logic [3:0] chan;
		logic [9:0] cnt;
		logic [3:0] pdiv;
		logic analog_conv_clock;
	} adcs_regs_s;
endpackage

/* File: hw/adcs_sequencer.sv */
// The AXI4-Lite interface to the registers was left to the implementer.
`include "adcs_consts.svh"
// How it works
// - Conversion clock is internal clock divided by prescale, then by two.
// - Sampling lasts 2*prescale*8 cycles, whole conversion 2*prescale*28 cycles.
// - Continuous bit set gives continuous mode, clear gives single; both scan.
// - Scan starts at first channel and steps by one up to 15.
// - Go bit set by software or trigger starts scan once power bit set; results go per channel.
// - Single mode clears go after channel 15, flags end of conversion, idles.
// - Continuous mode restarts at first channel after 15 until go cleared.
// - End of conversion flag set every time channel 15 finishes.
// - Each new conversion overwrites that channel's stored result.
// - Pin and timer triggers gated by own enables, then ORed together.
// - Accepted trigger sets go; later triggers in continuous flow ignored.
// - Triggers arriving while go is set are ignored.
// - External trigger sets go even with power bit cleared.
// - Pair select maps watchdogs A and B onto two adjacent channels.
// - Result at or above upper, or below lower, sets request and flag.
// - Compare result register uses only top four bits, one per condition.
// - Four thresholds live in software-programmable register pairs.
// - Compare flags reset to zero and clear when watchdog request cleared.
// - Power bit resets cleared and halt mode forces it cleared.
// - Two maskable interrupts, fixed priority, programmable level up to seven.
// - Simultaneous requests: watchdog served first, end of conversion held pending.
// - Software writing one to either pending flag raises a request.
// - High register holds bits 9:2, low holds 1:0 on top, rest zero.
module adcs_sequencer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire adcs_pkg::adcs_axi_req_s axi_req,
	output adcs_pkg::adcs_axi_resp_s axi_resp,
	input wire logic external_trigger_in,
	input wire logic timer_trigger_in,
	input wire logic halt_mode_in,
	input wire logic [9:0] conv_result,
	output adcs_pkg::adcs_core_s core,
	output logic eoc_irq,
	output logic awd_irq,
	output logic [2:0] irq_level
);
	import adcs_pkg::*;

	adcs_regs_s q;
	adcs_regs_s d;
	logic aw_rdy;
	logic w_rdy;
	logic ar_rdy;
	logic wr_go;
	logic wen;
	logic [9:0] widx;
	logic [9:0] woff;
	logic [9:0] ridx;
	logic [9:0] roff;
	logic [7:0] rdat;
	logic [3:0] pre;
	logic [9:0] conv_len;
	logic [9:0] sample_len;
	logic done;
	logic trig_act;
	logic trig_ev;
	logic [3:0] pair_a;
	logic [3:0] pair_b;
	logic [3:0] crr_set;

	function automatic logic reg_hit(input logic [9:0] idx);
		logic [9:0] off;
		off = idx - `ADCS_IDX_THR;
		reg_hit = (idx < `ADCS_DATA_REGS) || (off < `ADCS_THR_REGS) ||
			(idx >= `ADCS_IDX_CTL_A && idx <= `ADCS_IDX_CRR);
	endfunction

	// ----------------------------------------------------------------
	// Read data selection
	// ----------------------------------------------------------------
	always_comb begin
		ridx = axi_req.araddr[`ADCS_ADDR_W-1:2];
		roff = ridx - `ADCS_IDX_THR;
		rdat = 8'h00;
		if (ridx < `ADCS_DATA_REGS) begin
			if (ridx[0]) begin
				rdat = {q.data[ridx[4:1]][1:0], 6'h00};
			end else begin
				rdat = q.data[ridx[4:1]][9:2];
			end
		end else if (roff < `ADCS_THR_REGS) begin
			if (roff[0]) begin
				rdat = {q.thr[roff[2:1]][1:0], 6'h00};
			end else begin
				rdat = q.thr[roff[2:1]][9:2];
			end
		end else begin
			case (ridx)
				`ADCS_IDX_CTL_A: rdat = q.ctl_a;
				`ADCS_IDX_CTL_B: rdat = q.ctl_b;
				`ADCS_IDX_ICR: rdat = q.interrupt_control_reg;
				`ADCS_IDX_CRR: rdat = {q.compare_result_flags, 4'h0};
				default: rdat = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		aw_rdy = !q.aw_v && !q.b_v;
		w_rdy = !q.w_v && !q.b_v;
		ar_rdy = !q.r_v;
		wr_go = q.aw_v && q.w_v;
		wen = wr_go && q.w_s;
		widx = q.aw_a[`ADCS_ADDR_W-1:2];
		woff = widx - `ADCS_IDX_THR;
		if (axi_req.awvalid && aw_rdy) begin
			d.aw_v = 1'b1;
			d.aw_a = axi_req.awaddr;
		end
		if (axi_req.wvalid && w_rdy) begin
			d.w_v = 1'b1;
			d.w_d = axi_req.wdata[7:0];
			d.w_s = axi_req.wstrb[0];
		end
		if (wr_go) begin
			d.aw_v = 1'b0;
			d.w_v = 1'b0;
			d.b_v = 1'b1;
			d.b_r = reg_hit(widx) ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
		end
		if (q.b_v && axi_req.bready) begin
			d.b_v = 1'b0;
		end
		if (axi_req.arvalid && ar_rdy) begin
			d.r_v = 1'b1;
			d.r_d = rdat;
			d.r_r = reg_hit(ridx) ? `ADCS_RESP_OKAY : `ADCS_RESP_SLVERR;
		end
		if (q.r_v && axi_req.rready) begin
			d.r_v = 1'b0;
		end
		// Software writes; hardware events below take precedence.
		if (wen) begin
			if (widx < `ADCS_DATA_REGS) begin
				if (widx[0]) begin
					d.data[widx[4:1]][1:0] = q.w_d[7:6];
				end else begin
					d.data[widx[4:1]][9:2] = q.w_d;
				end
			end else if (woff < `ADCS_THR_REGS) begin
				if (woff[0]) begin
					d.thr[woff[2:1]][1:0] = q.w_d[7:6];
				end else begin
					d.thr[woff[2:1]][9:2] = q.w_d;
				end
			end else begin
				case (widx)
					`ADCS_IDX_CTL_A: d.ctl_a = q.w_d;
					`ADCS_IDX_CTL_B: d.ctl_b = q.w_d;
					`ADCS_IDX_ICR: begin
						if (q.interrupt_control_reg[`ADCS_IC_AWD] && !q.w_d[`ADCS_IC_AWD]) begin
							d.compare_result_flags = 4'h0;
						end
						d.interrupt_control_reg = q.w_d;
					end
					default: ;
				endcase
			end
		end
		// A zero prescale field is taken as the largest divide.
		pre = (q.ctl_b[`ADCS_CB_PRE] == 3'h0) ? `ADCS_PRE_ZERO : {1'b0, q.ctl_b[`ADCS_CB_PRE]};
		conv_len = 10'({6'h00, pre} * `ADCS_CONV_MUL * 10'h002);
		sample_len = 10'({6'h00, pre} * `ADCS_SAMPLE_MUL * 10'h002);
		if (q.pdiv >= pre - 4'h1) begin
			d.pdiv = 4'h0;
			d.analog_conv_clock = !q.analog_conv_clock;
		end else begin
			d.pdiv = q.pdiv + 4'h1;
		end
		// A conversion cut short by clearing go or power is neither stored nor compared.
		done = (q.st == ADCS_CONV) && (q.cnt == conv_len - 10'h001) &&
			q.ctl_b[`ADCS_CB_GO] && q.ctl_b[`ADCS_CB_POW];
		pair_a = q.ctl_a[`ADCS_CA_PAIR];
		pair_b = pair_a + 4'h1;
		crr_set = 4'h0;
		if (done && q.chan == pair_a) begin
			crr_set[3] = conv_result >= q.thr[0];
			crr_set[2] = conv_result < q.thr[1];
		end
		if (done && q.chan == pair_b) begin
			crr_set[1] = conv_result >= q.thr[2];
			crr_set[0] = conv_result < q.thr[3];
		end
		d.compare_result_flags = d.compare_result_flags | crr_set;
		if (crr_set != 4'h0) begin
			d.interrupt_control_reg[`ADCS_IC_AWD] = 1'b1;
		end
		case (q.st)
			ADCS_IDLE: begin
				if (q.ctl_b[`ADCS_CB_GO] && q.ctl_b[`ADCS_CB_POW]) begin
					d.st = ADCS_CONV;
					d.chan = q.ctl_a[`ADCS_CA_FIRST];
					d.cnt = 10'h000;
				end
			end
			ADCS_CONV: begin
				if (!q.ctl_b[`ADCS_CB_GO] || !q.ctl_b[`ADCS_CB_POW]) begin
					d.st = ADCS_IDLE;
				end else if (done) begin
					d.data[q.chan] = conv_result;
					d.cnt = 10'h000;
					if (q.chan == `ADCS_LAST_CH) begin
						d.interrupt_control_reg[`ADCS_IC_EOC] = 1'b1;
						if (q.ctl_b[`ADCS_CB_CONT]) begin
							d.chan = q.ctl_a[`ADCS_CA_FIRST];
						end else begin
							d.ctl_b[`ADCS_CB_GO] = 1'b0;
							d.st = ADCS_IDLE;
						end
					end else begin
						d.chan = q.chan + 4'h1;
					end
				end else begin
					d.cnt = q.cnt + 10'h001;
				end
			end
			default: d.st = ADCS_IDLE;
		endcase
		// Trigger sources are active low; an event is the start of a low phase.
		d.ext_s1 = external_trigger_in;
		d.ext_s2 = q.ext_s1;
		trig_act = (!q.ext_s2 && q.ctl_b[`ADCS_CB_EXT]) ||
			(!timer_trigger_in && q.ctl_b[`ADCS_CB_TIMER]);
		d.trig_q = trig_act;
		trig_ev = trig_act && !q.trig_q;
		if (trig_ev && !q.ctl_b[`ADCS_CB_GO]) begin
			d.ctl_b[`ADCS_CB_GO] = 1'b1;
		end
		if (halt_mode_in) begin
			d.ctl_b[`ADCS_CB_POW] = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		axi_resp.awready = aw_rdy;
		axi_resp.wready = w_rdy;
		axi_resp.bvalid = q.b_v;
		axi_resp.bresp = q.b_r;
		axi_resp.arready = ar_rdy;
		axi_resp.rvalid = q.r_v;
		axi_resp.rdata = {24'h00_0000, q.r_d};
		axi_resp.rresp = q.r_r;
		core.power_up = q.ctl_b[`ADCS_CB_POW];
		core.conv_clock = q.analog_conv_clock;
		core.sample = (q.st == ADCS_CONV) && (q.cnt < sample_len);
		core.busy = q.st == ADCS_CONV;
		core.channel = q.chan;
		awd_irq = q.interrupt_control_reg[`ADCS_IC_AWD] && q.interrupt_control_reg[`ADCS_IC_AWD_EN];
		eoc_irq = q.interrupt_control_reg[`ADCS_IC_EOC] && q.interrupt_control_reg[`ADCS_IC_EOC_EN] && !awd_irq;
		irq_level = q.interrupt_control_reg[`ADCS_IC_LVL];
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	go_clear_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && q.chan == `ADCS_LAST_CH && !q.ctl_b[`ADCS_CB_CONT]) |=>
		(!q.ctl_b[`ADCS_CB_GO] && q.st == ADCS_IDLE))
		else $error("go bit not cleared after last channel in single mode");
	eoc_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && q.chan == `ADCS_LAST_CH) |=> q.interrupt_control_reg[`ADCS_IC_EOC])
		else $error("end of conversion flag not set");
	scan_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && q.chan == `ADCS_LAST_CH && q.ctl_b[`ADCS_CB_CONT]) |=>
		(q.chan == $past(q.ctl_a[`ADCS_CA_FIRST]) && q.st == ADCS_CONV))
		else $error("continuous scan did not restart at first channel");
	chan_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && q.chan != `ADCS_LAST_CH) |=> q.chan == $past(q.chan) + 4'h1)
		else $error("channel did not advance by one");
	result_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done |=> q.data[$past(q.chan)] == $past(conv_result))
		else $error("result not stored in channel register");
	trig_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(trig_ev && !q.ctl_b[`ADCS_CB_GO]) |=> q.ctl_b[`ADCS_CB_GO])
		else $error("accepted trigger did not set go bit");
	sample_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ADCS_CONV && q.cnt == sample_len && $stable(sample_len)) |->
		(!core.sample && $past(core.sample)))
		else $error("sampling window has wrong length");
	awd_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(crr_set != 4'h0) |=> (q.interrupt_control_reg[`ADCS_IC_AWD] && (q.compare_result_flags & $past(crr_set)) == $past(crr_set)))
		else $error("watchdog hit not flagged");
	crr_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wen && widx == `ADCS_IDX_ICR && q.interrupt_control_reg[`ADCS_IC_AWD] && !q.w_d[`ADCS_IC_AWD] &&
		crr_set == 4'h0) |=> q.compare_result_flags == 4'h0)
		else $error("compare flags not cleared with watchdog request");
	halt_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_mode_in |=> (!core.power_up ##1 (q.st == ADCS_IDLE)))
		else $error("halt did not force power down");
	irq_priority_a: assert property (@(posedge aclk) disable iff (!aresetn)
		awd_irq |-> !eoc_irq)
		else $error("end of conversion served before watchdog");
	scan_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ADCS_IDLE && q.ctl_b[`ADCS_CB_GO] && q.ctl_b[`ADCS_CB_POW]) |=>
		(q.st == ADCS_CONV && q.chan == $past(q.ctl_a[`ADCS_CA_FIRST]) && q.cnt == 10'h000))
		else $error("scan did not start at first channel");
	idle_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ADCS_IDLE && !q.ctl_b[`ADCS_CB_GO]) |=> q.st == ADCS_IDLE)
		else $error("scan started without go bit");
	scan_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ADCS_CONV && !q.ctl_b[`ADCS_CB_GO]) |=> q.st == ADCS_IDLE)
		else $error("scan kept running after go bit cleared");
	cont_keep_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ADCS_CONV && q.ctl_b[`ADCS_CB_CONT] && q.ctl_b[`ADCS_CB_GO] &&
		!(wen && widx == `ADCS_IDX_CTL_B)) |=> q.ctl_b[`ADCS_CB_GO])
		else $error("continuous scan dropped go bit");
	chan_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == ADCS_CONV && !done) |=> q.chan == $past(q.chan))
		else $error("channel changed during a conversion");
	eoc_only_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && q.chan != `ADCS_LAST_CH && !q.interrupt_control_reg[`ADCS_IC_EOC] &&
		!(wen && widx == `ADCS_IDX_ICR)) |=> !q.interrupt_control_reg[`ADCS_IC_EOC])
		else $error("end of conversion flag set before last channel");
	eoc_pending_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.interrupt_control_reg[`ADCS_IC_EOC] && awd_irq && !(wen && widx == `ADCS_IDX_ICR)) |=>
		q.interrupt_control_reg[`ADCS_IC_EOC])
		else $error("end of conversion request lost behind watchdog");
	in_range_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(done && q.chan == pair_a && conv_result < q.thr[0] && conv_result >= q.thr[1]) |->
		crr_set[3:2] == 2'b00)
		else $error("in-range result flagged on watchdog A");
	low_reg_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(axi_req.arvalid && ar_rdy && ridx < `ADCS_DATA_REGS && ridx[0]) |=>
		q.r_d[5:0] == 6'h00)
		else $error("low data register unused bits not zero");
	analog_conv_clock_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.pdiv >= pre - 4'h1) |=> q.analog_conv_clock != $past(q.analog_conv_clock))
		else $error("conversion clock did not toggle");
	analog_conv_clock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.pdiv < pre - 4'h1) |=> $stable(q.analog_conv_clock))
		else $error("conversion clock toggled early");
endmodule // adcs_sequencer

/* File: sim/adcs_conv_model.sv */
module adcs_conv_model (
	input wire logic aclk,
	input wire adcs_pkg::adcs_core_s core,
	input wire logic [9:0] level,
	output logic [9:0] conv_result
);
	timeunit 1ns;
	timeprecision 1ps;
	import adcs_pkg::*;
	logic [9:0] last_q = 10'h155;
	always_ff @(posedge aclk) begin
		last_q <= conv_result;
	end
	// A powered, busy core returns a distinct 10-bit code per channel; otherwise the output
	// is the inverse of its value one cycle earlier, so it flips every cycle instead of keeping a stale value.
	assign conv_result = (core.busy && core.power_up) ? level + 10'(core.channel) : ~last_q;
endmodule // adcs_conv_model

/* File: sim/adcs_sequencer_tb_top.sv */
`include "adcs_consts.svh"
`define CHK(n, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("mismatch %s exp %h got %h", n, e, g); \
	end \
end
module adcs_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adcs_pkg::*;
	logic aclk, aresetn, ext_n, tmr_n, halt, ck_prev;
	adcs_axi_req_s req;
	adcs_axi_resp_s rsp;
	adcs_core_s core;
	logic eoc_irq, awd_irq;
	logic [2:0] lvl;
	logic [9:0] res, level, v;
	logic [15:0] lfsr = 16'ha5ec;
	logic [33:0] e;
	logic [33:0] exp_q[$];
	int fails, checks_done, cyc, busy_n, samp_n, ck_n, ch_sum;

	adcs_sequencer adcs_sequencer_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_resp(rsp),
		.external_trigger_in(ext_n), .timer_trigger_in(tmr_n), .halt_mode_in(halt),
		.conv_result(res), .core(core), .eoc_irq(eoc_irq), .awd_irq(awd_irq), .irq_level(lvl));
	adcs_conv_model adcs_conv_model_i (.aclk(aclk), .core(core), .level(level), .conv_result(res));

	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic give_verdict();
		if (fails == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic a, w, ha, hw;
		exp_q.push_back({er, 32'h0000_0000});
		req.awvalid <= 1'b1;
		req.awaddr <= {idx, 2'h0};
		req.wvalid <= 1'b1;
		req.wdata <= {24'h00_0000, d};
		a = 1'b0;
		w = 1'b0;
		while (!(a && w)) begin
			@(negedge aclk);
			ha = rsp.awready & req.awvalid;
			hw = rsp.wready & req.wvalid;
			@(posedge aclk);
			if (ha) begin
				a = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (hw) begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do begin
			@(negedge aclk);
			ha = rsp.bvalid;
			@(posedge aclk);
		end while (ha !== 1'b1);
	endtask

	task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic hs;
		exp_q.push_back({er, 24'h00_0000, d});
		req.arvalid <= 1'b1;
		req.araddr <= {idx, 2'h0};
		do begin
			@(negedge aclk);
			hs = rsp.arready;
			@(posedge aclk);
		end while (hs !== 1'b1);
		req.arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			hs = rsp.rvalid;
			@(posedge aclk);
		end while (hs !== 1'b1);
	endtask

	task automatic wait_irq(input logic wd);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while ((wd ? awd_irq : eoc_irq) !== 1'b1 && n < 2000);
		`CHK("irq", 1'b1, wd ? awd_irq : eoc_irq)
		@(posedge aclk);
	endtask

	task automatic pulse(input logic ext);
		if (ext) ext_n <= 1'b0;
		else tmr_n <= 1'b0;
		repeat (2) @(posedge aclk);
		ext_n <= 1'b1;
		tmr_n <= 1'b1;
	endtask

	task automatic thr(input int k, input logic [9:0] t);
		wr(10'h0f4 + 10'(2 * k), t[9:2]);
		wr(10'h0f5 + 10'(2 * k), {t[1:0], 6'h00});
	endtask

	task automatic chk_data(input logic [3:0] ch);
		v = level + 10'(ch);
		rd({5'h00, ch, 1'b0}, v[9:2]);
		rd({5'h00, ch, 1'b1}, {v[1:0], 6'h00});
	endtask

	task automatic new_level();
		lfsr = nxt(lfsr);
		level <= {1'b0, lfsr[8:0]};
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			give_verdict();
		end
	end

	// Bus answers are matched against the oldest expectation noted by the driver.
	always @(negedge aclk) begin
		busy_n += (core.busy === 1'b1);
		samp_n += (core.sample === 1'b1);
		ck_n += (core.busy === 1'b1 && core.conv_clock === 1'b1 && ck_prev === 1'b0);
		ch_sum += (core.busy === 1'b1) ? int'(core.channel) : 0;
		ck_prev = core.conv_clock;
		if ((rsp.rvalid & req.rready) === 1'b1) begin
			e = exp_q.pop_front();
			`CHK("read", e, {rsp.rresp, rsp.rdata})
		end
		if ((rsp.bvalid & req.bready) === 1'b1) begin
			e = exp_q.pop_front();
			`CHK("bresp", e[33:32], rsp.bresp)
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		req = '0;
		req.wstrb = 4'hf;
		req.bready = 1'b1;
		req.rready = 1'b1;
		aresetn = 1'b0;
		ext_n = 1'b1;
		tmr_n = 1'b1;
		halt = 1'b0;
		level = 10'h000;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`ADCS_IDX_CTL_B, 8'h00);
		rd(`ADCS_IDX_CRR, 8'h00);
		rd(10'h100, 8'h00, `ADCS_RESP_SLVERR);
		wr(10'h100, 8'h5a, `ADCS_RESP_SLVERR);
		new_level();
		wr(`ADCS_IDX_CTL_A, 8'h0d);
		wr(`ADCS_IDX_ICR, 8'h35);
		wr(`ADCS_IDX_CTL_B, 8'h44);
		repeat (1000) @(posedge aclk);
		busy_n = 0;
		samp_n = 0;
		ck_n = 0;
		ch_sum = 0;
		wr(`ADCS_IDX_CTL_B, 8'h45);
		wait_irq(1'b0);
		`CHK("busy", 336, busy_n)
		`CHK("conv clock", 32'h0000_0054, ck_n)
		`CHK("channel", 32'h0000_1260, ch_sum)
		`CHK("sample", 96, samp_n)
		`CHK("level", 3'h5, lvl)
		rd(`ADCS_IDX_CTL_B, 8'h44);
		for (int c = 13; c < 16; c++) chk_data(4'(c));
		rd(10'h018, 8'h00);
		wr(`ADCS_IDX_ICR, 8'h95);
		`CHK("eoc masked", 1'b0, eoc_irq)
		wr(`ADCS_IDX_ICR, 8'h35);
		`CHK("eoc cleared", 1'b0, eoc_irq)
		wr(`ADCS_IDX_ICR, 8'hb5);
		`CHK("eoc by write", 1'b1, eoc_irq)
		wr(`ADCS_IDX_ICR, 8'h35);
		wr(`ADCS_IDX_CTL_A, 8'h0e);
		wr(`ADCS_IDX_CTL_B, 8'h36);
		pulse(1'b0);
		wait_irq(1'b0);
		new_level();
		wr(`ADCS_IDX_ICR, 8'h35);
		wait_irq(1'b0);
		wr(`ADCS_IDX_CTL_B, 8'h36);
		@(negedge aclk);
		`CHK("stopped", 1'b0, core.busy)
		@(posedge aclk);
		chk_data(4'he);
		chk_data(4'hf);
		wr(`ADCS_IDX_ICR, 8'h35);
		v = level + 10'h00e;
		thr(0, v);
		thr(1, v);
		thr(2, 10'h3ff);
		thr(3, level + 10'h010);
		wr(`ADCS_IDX_CTL_A, 8'hee);
		wr(`ADCS_IDX_CTL_B, 8'h25);
		wait_irq(1'b1);
		repeat (60) @(posedge aclk);
		`CHK("eoc held", 1'b0, eoc_irq)
		rd(`ADCS_IDX_CRR, 8'h90);
		wr(`ADCS_IDX_ICR, 8'hb5);
		`CHK("eoc after wd", 1'b1, eoc_irq)
		rd(`ADCS_IDX_CRR, 8'h00);
		wr(`ADCS_IDX_ICR, 8'h75);
		`CHK("wd by write", 1'b1, awd_irq)
		wr(`ADCS_IDX_ICR, 8'h35);
		wr(`ADCS_IDX_CTL_B, 8'h28);
		pulse(1'b0);
		rd(`ADCS_IDX_CTL_B, 8'h28);
		pulse(1'b1);
		repeat (4) @(posedge aclk);
		rd(`ADCS_IDX_CTL_B, 8'h29);
		`CHK("idle unpowered", 1'b0, core.busy)
		wr(`ADCS_IDX_CTL_B, 8'h2c);
		halt <= 1'b1;
		@(posedge aclk);
		halt <= 1'b0;
		@(posedge aclk);
		`CHK("halt power", 1'b0, core.power_up)
		give_verdict();
	end
endmodule // adcs_sequencer_tb_top
